// File: vpic_pkg.sv
// constants, types and timing for the video preamp serial host controller
package vpic_pkg;

	// ------------------------------------------------------------
	// serial link constants
	// ------------------------------------------------------------
	localparam logic [6:0] DEV_ADDR   = 7'h6E;  // 1101110, write form DC
	localparam logic       DIR_WRITE  = 1'h0;   // read/write bit for a write
	localparam int         BYTE_BITS  = 8;      // data bits in a byte
	localparam logic [3:0] ACK_BIT    = 4'h8;   // ninth bit slot
	localparam logic [1:0] LAST_QTR   = 2'h3;   // last quarter of a bit

	// ------------------------------------------------------------
	// device register numbers and power-on values
	// ------------------------------------------------------------
	localparam int         NUM_DEV_REGS  = 12;     // registers 1 to 12
	localparam logic [3:0] REG_CONTRAST  = 4'h1;
	localparam logic [3:0] REG_BRIGHT    = 4'h2;
	localparam logic [3:0] REG_DRIVE_R   = 4'h3;
	localparam logic [3:0] REG_DRIVE_B   = 4'h5;
	localparam logic [3:0] REG_CLAMP     = 4'h8;
	localparam logic [3:0] REG_MODE      = 4'h9;
	localparam logic [7:0] RST_GAIN      = 8'hB4;  // 180 decimal
	localparam logic [7:0] RST_OTHER     = 8'h00;
	localparam int         CLAMP_ROUTE_B = 7;      // register 8 bit 7
	localparam int         MODE_B2       = 2;      // register 9 bits
	localparam int         MODE_B3       = 3;
	localparam int         MODE_B4       = 4;

	// ------------------------------------------------------------
	// software register map of the controller
	// ------------------------------------------------------------
	localparam int         SW_AW      = 5;
	localparam logic [4:0] A_CTRL     = 5'h10;  // go, mode, no blanking
	localparam logic [4:0] A_STATUS   = 5'h11;  // busy, nack sticky
	localparam logic [4:0] A_RANGE    = 5'h12;  // first and last register
	localparam int         CTRL_GO    = 0;
	localparam int         CTRL_MODE  = 1;      // two bits, 2:1
	localparam int         CTRL_NOBLK = 3;
	localparam int         STAT_BUSY  = 0;
	localparam int         STAT_NACK  = 1;
	localparam logic [7:0] RST_CTRL   = 8'h00;
	localparam logic [7:0] RST_RANGE  = 8'hC1;  // registers 1 to 12

	// ------------------------------------------------------------
	// timing: one quarter of a serial bit
	// ------------------------------------------------------------
	localparam int CLK_MHZ      = 250;
	localparam int QUARTER_NS   = 2500;         // 100 kHz bit rate
	localparam int QUARTER_CYC  = (QUARTER_NS * CLK_MHZ + 999) / 1000;

	// ------------------------------------------------------------
	// types
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		MODE_KEEP     = 2'h0,  // send register 9 as stored
		MODE_DC_PLAIN = 2'h1,
		MODE_AC_CUT   = 2'h2,
		MODE_DC_FB    = 2'h3
	} vpic_mode_e;

	typedef enum logic [3:0] {
		S_IDLE  = 4'h1,
		S_START = 4'h2,
		S_XFER  = 4'h4,
		S_STOP  = 4'h8
	} vpic_state_e;

	typedef enum logic [1:0] {
		K_ADDR = 2'h0,
		K_REG  = 2'h1,
		K_DATA = 2'h2
	} vpic_kind_e;

	typedef struct packed {
		logic [4:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} vpic_bus_s;

	typedef struct packed {
		logic scl_low;  // pull clock line low
		logic sda_low;  // pull data line low
	} vpic_pins_s;

endpackage

// File: vpic_sync.sv
// two flip-flop synchroniser for inputs from outside the clock domain
`timescale 1ns/10ps
module vpic_sync #(
	parameter int W = 1
) (
	// clock, reset, enable
	input  wire logic         clk,
	input  wire logic         rst,
	input  wire logic         ce,
	// signals
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);

	logic [W-1:0] meta_reg;  // first stage, read only by q
	logic [W-1:0] meta_next;
	logic [W-1:0] q_next;

	// ------------------------------------------------------------
	// next values
	// ------------------------------------------------------------
	always_comb begin
		meta_next = ce ? d : meta_reg;
		q_next    = ce ? meta_reg : q;
	end

	// released lines idle high
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			meta_reg <= '1;
			q        <= '1;
		end else begin
			meta_reg <= meta_next;
			q        <= q_next;
		end
	end

endmodule // vpic_sync

// File: vpic_tick.sv
// divider giving one pulse per quarter of a serial bit
`timescale 1ns/10ps
module vpic_tick #(
	parameter int DIV = 625
) (
	// clock, reset, enable
	input  wire logic clk,
	input  wire logic rst,
	input  wire logic ce,
	// control
	input  wire logic run,
	output logic      tick
);

	localparam int CW = $clog2(DIV + 1);

	if (DIV < 2) begin : g_chk
		$error("vpic_tick: DIV must be at least 2");
	end

	logic [CW-1:0] cnt_reg;  // cycles within the quarter
	logic [CW-1:0] cnt_next;

	// ------------------------------------------------------------
	// count while running, restart when stopped
	// ------------------------------------------------------------
	always_comb begin
		tick     = run && (cnt_reg == CW'(DIV - 1));
		cnt_next = cnt_reg;
		if (ce) begin
			if (!run || tick) begin
				cnt_next = '0;
			end else begin
				cnt_next = cnt_reg + CW'(1);
			end
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cnt_reg <= '0;
		end else begin
			cnt_reg <= cnt_next;
		end
	end

endmodule // vpic_tick

// File: vpic_host.sv
// serial bus master that programs the video preamp control registers
//
// The register offsets and strobed register access were decided locally.
`timescale 1ns/10ps
module vpic_host #(
	parameter int QUARTER = vpic_pkg::QUARTER_CYC
) (
	// clock, reset, enable
	input  wire logic              clk,
	input  wire logic              rst,
	input  wire logic              ce,
	// software register port
	input  wire vpic_pkg::vpic_bus_s bus,
	output logic             [7:0] rdata,
	// serial clock line, open drain
	input  wire logic              scl_in,
	output logic                   scl_out,
	output logic                   scl_oe,
	// serial data line, open drain
	input  wire logic              sda_in,
	output logic                   sda_out,
	output logic                   sda_oe
);

	if (QUARTER < 4) begin : g_chk
		$error("vpic_host: QUARTER too short for synchroniser delay");
	end

	// ------------------------------------------------------------
	// declarations
	// ------------------------------------------------------------
	logic [7:0]            shadow_reg [1:vpic_pkg::NUM_DEV_REGS];
	logic [7:0]            shadow_next[1:vpic_pkg::NUM_DEV_REGS];
	logic [7:0]            ctrl_reg;     // mode and no-blank option
	logic [7:0]            ctrl_next;
	logic [7:0]            range_reg;    // last in 7:4, first in 3:0
	logic [7:0]            range_next;
	logic                  nack_reg;     // sticky missing acknowledge
	logic                  nack_next;
	logic [7:0]            rdata_next;
	vpic_pkg::vpic_state_e state_reg;
	vpic_pkg::vpic_state_e state_next;
	vpic_pkg::vpic_kind_e  kind_reg;     // byte now on the wire
	vpic_pkg::vpic_kind_e  kind_next;
	logic [1:0]            qtr_reg;      // quarter within a bit
	logic [1:0]            qtr_next;
	logic [3:0]            bit_reg;      // 0-7 data, 8 acknowledge
	logic [3:0]            bit_next;
	logic [7:0]            shift_reg;    // outgoing byte
	logic [7:0]            shift_next;
	logic [3:0]            idx_reg;      // device register in flight
	logic [3:0]            idx_next;
	vpic_pkg::vpic_pins_s  pins_reg;
	vpic_pkg::vpic_pins_s  pins_next;
	logic [1:0]            line_s;       // synchronised scl, sda
	logic                  tick;
	logic                  stretched;    // device holds clock low
	logic                  adv;          // quarter completes
	logic                  go;
	logic                  nack_set;
	logic [3:0]            first_idx;
	logic [3:0]            last_idx;
	logic                  range_ok;

	// ------------------------------------------------------------
	// submodules
	// ------------------------------------------------------------
	vpic_sync #(
		.W (2)
	) u_sync (
		.clk (clk),
		.rst (rst),
		.ce  (ce),
		.d   ({scl_in, sda_in}),
		.q   (line_s)
	);

	vpic_tick #(
		.DIV (QUARTER)
	) u_tick (
		.clk  (clk),
		.rst  (rst),
		.ce   (ce),
		.run  (state_reg != vpic_pkg::S_IDLE),
		.tick (tick)
	);

	// ------------------------------------------------------------
	// helper functions
	// ------------------------------------------------------------
	// power-on value the device itself holds for a register
	function automatic logic [7:0] por_value(input int i);
		if (i == int'(vpic_pkg::REG_CONTRAST) ||
		    (i >= int'(vpic_pkg::REG_DRIVE_R) &&
		     i <= int'(vpic_pkg::REG_DRIVE_B))) begin
			return vpic_pkg::RST_GAIN;
		end
		return vpic_pkg::RST_OTHER;
	endfunction

	// data byte sent for a register, with mode and blanking overrides
	function automatic logic [7:0] out_value(input logic [3:0] i,
	                                         input logic [7:0] v,
	                                         input logic [7:0] c);
		logic [7:0] r;
		r = v;
		if (i == vpic_pkg::REG_MODE) begin
			unique case (vpic_pkg::vpic_mode_e'(c[2:1]))
				vpic_pkg::MODE_KEEP: begin
					r = v;
				end
				vpic_pkg::MODE_DC_PLAIN: begin
					r[vpic_pkg::MODE_B2] = 1'b1;
					r[vpic_pkg::MODE_B3] = 1'b0;
				end
				vpic_pkg::MODE_AC_CUT: begin
					r[vpic_pkg::MODE_B2] = 1'b1;
					r[vpic_pkg::MODE_B3] = 1'b1;
					r[vpic_pkg::MODE_B4] = 1'b1;
				end
				vpic_pkg::MODE_DC_FB: begin
					r[vpic_pkg::MODE_B2] = 1'b0;
					r[vpic_pkg::MODE_B4] = 1'b0;
				end
			endcase
		end
		if (c[vpic_pkg::CTRL_NOBLK]) begin
			if (i == vpic_pkg::REG_BRIGHT) begin
				r = 8'h00;
			end
			if (i == vpic_pkg::REG_CLAMP) begin
				r[vpic_pkg::CLAMP_ROUTE_B] = 1'b1;
			end
		end
		return r;
	endfunction

	// ------------------------------------------------------------
	// software register next values
	// ------------------------------------------------------------
	assign first_idx = range_reg[3:0];
	assign last_idx  = range_reg[7:4];
	assign range_ok  = (first_idx != 4'h0) && (first_idx <= last_idx) &&
	                   (last_idx <= 4'(vpic_pkg::NUM_DEV_REGS));
	assign go        = ce && bus.wr && (bus.addr == vpic_pkg::A_CTRL) &&
	                   bus.wdata[vpic_pkg::CTRL_GO] &&
	                   (state_reg == vpic_pkg::S_IDLE) && range_ok;

	always_comb begin
		shadow_next = shadow_reg;
		ctrl_next   = ctrl_reg;
		range_next  = range_reg;
		nack_next   = nack_reg;
		rdata_next  = rdata;
		if (ce) begin
			// writes; settings hold while a transfer runs
			if (bus.wr && state_reg == vpic_pkg::S_IDLE) begin
				for (int i = 1; i <= vpic_pkg::NUM_DEV_REGS; i++) begin
					if (bus.addr == 5'(i)) begin
						shadow_next[i] = bus.wdata;
					end
				end
				if (bus.addr == vpic_pkg::A_CTRL) begin
					ctrl_next = {4'h0, bus.wdata[3:1], 1'b0};
				end
				if (bus.addr == vpic_pkg::A_RANGE) begin
					range_next = bus.wdata;
				end
			end
			if (bus.wr && bus.addr == vpic_pkg::A_STATUS &&
			    bus.wdata[vpic_pkg::STAT_NACK]) begin
				nack_next = 1'b0;  // write one to clear
			end
			if (nack_set) begin
				nack_next = 1'b1;  // set wins over clear
			end
			// reads answer the cycle after the strobe
			rdata_next = 8'h00;
			if (bus.rd) begin
				for (int i = 1; i <= vpic_pkg::NUM_DEV_REGS; i++) begin
					if (bus.addr == 5'(i)) begin
						rdata_next = shadow_reg[i];
					end
				end
				if (bus.addr == vpic_pkg::A_CTRL) begin
					rdata_next = ctrl_reg;
				end
				if (bus.addr == vpic_pkg::A_STATUS) begin
					rdata_next = {6'h00, nack_reg,
					              state_reg != vpic_pkg::S_IDLE};
				end
				if (bus.addr == vpic_pkg::A_RANGE) begin
					rdata_next = range_reg;
				end
			end
		end
	end

	// software registers; shadow mirrors the device power-on state
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			for (int i = 1; i <= vpic_pkg::NUM_DEV_REGS; i++) begin
				shadow_reg[i] <= por_value(i);
			end
			ctrl_reg  <= vpic_pkg::RST_CTRL;
			range_reg <= vpic_pkg::RST_RANGE;
			nack_reg  <= 1'b0;
			rdata     <= 8'h00;
		end else begin
			shadow_reg <= shadow_next;
			ctrl_reg   <= ctrl_next;
			range_reg  <= range_next;
			nack_reg   <= nack_next;
			rdata      <= rdata_next;
		end
	end

	// ------------------------------------------------------------
	// serial sequencer next values
	// ------------------------------------------------------------
	// a released clock still read low means the device stretches it
	assign stretched = !pins_reg.scl_low && !line_s[1];
	assign adv       = ce && tick && !stretched;

	always_comb begin
		state_next = state_reg;
		kind_next  = kind_reg;
		qtr_next   = qtr_reg;
		bit_next   = bit_reg;
		shift_next = shift_reg;
		idx_next   = idx_reg;
		nack_set   = 1'b0;
		unique case (state_reg)
			vpic_pkg::S_IDLE: begin
				if (go) begin
					state_next = vpic_pkg::S_START;
					qtr_next   = 2'h0;
					kind_next  = vpic_pkg::K_ADDR;
					shift_next = {vpic_pkg::DEV_ADDR,
					              vpic_pkg::DIR_WRITE};
					idx_next   = first_idx;
				end
			end
			vpic_pkg::S_START: begin
				if (adv) begin
					qtr_next = qtr_reg + 2'h1;
					if (qtr_reg == vpic_pkg::LAST_QTR) begin
						state_next = vpic_pkg::S_XFER;
						bit_next   = 4'h0;
					end
				end
			end
			vpic_pkg::S_XFER: begin
				if (adv) begin
					qtr_next = qtr_reg + 2'h1;
					if (qtr_reg == vpic_pkg::LAST_QTR) begin
						if (bit_reg != vpic_pkg::ACK_BIT) begin
							bit_next   = bit_reg + 4'h1;
							shift_next = {shift_reg[6:0], 1'b0};
						end else if (line_s[0]) begin
							nack_set   = 1'b1;
							state_next = vpic_pkg::S_STOP;
						end else begin
							bit_next = 4'h0;
							unique case (kind_reg)
								vpic_pkg::K_ADDR: begin
									kind_next  = vpic_pkg::K_REG;
									shift_next = {4'h0, idx_reg};
								end
								vpic_pkg::K_REG: begin
									kind_next  = vpic_pkg::K_DATA;
									shift_next = out_value(idx_reg,
									                       shadow_reg[idx_reg],
									                       ctrl_reg);
								end
								default: begin
									if (idx_reg == last_idx) begin
										state_next = vpic_pkg::S_STOP;
									end else begin
										kind_next  = vpic_pkg::K_REG;
										idx_next   = idx_reg + 4'h1;
										shift_next = {4'h0, idx_reg + 4'h1};
									end
								end
							endcase
						end
					end
				end
			end
			vpic_pkg::S_STOP: begin
				if (adv) begin
					qtr_next = qtr_reg + 2'h1;
					if (qtr_reg == vpic_pkg::LAST_QTR) begin
						state_next = vpic_pkg::S_IDLE;
					end
				end
			end
			default: begin
				state_next = vpic_pkg::S_IDLE;
			end
		endcase
	end

	// ------------------------------------------------------------
	// pin drive, computed from the next sequencer position
	// ------------------------------------------------------------
	// within a byte, data only changes one quarter after the clock falls
	always_comb begin
		pins_next = pins_reg;
		if (ce) begin
			unique case (state_next)
				vpic_pkg::S_IDLE: begin
					pins_next = '{scl_low: 1'b0, sda_low: 1'b0};
				end
				vpic_pkg::S_START: begin
					pins_next.scl_low = 1'b0;
					pins_next.sda_low = qtr_next[1];  // start condition
				end
				vpic_pkg::S_XFER: begin
					pins_next.scl_low = !qtr_next[1];
					if (qtr_next != 2'h0) begin
						pins_next.sda_low = (bit_next != vpic_pkg::ACK_BIT) &&
						                    !shift_next[7];
					end
				end
				vpic_pkg::S_STOP: begin
					pins_next.scl_low = (qtr_next == 2'h0) ||
					                    (qtr_next == 2'h1);
					if (qtr_next != 2'h0) begin
						pins_next.sda_low = (qtr_next != vpic_pkg::LAST_QTR);
					end
				end
				default: begin
					pins_next = '{scl_low: 1'b0, sda_low: 1'b0};
				end
			endcase
		end
	end

	// sequencer and pin registers
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state_reg <= vpic_pkg::S_IDLE;
			kind_reg  <= vpic_pkg::K_ADDR;
			qtr_reg   <= 2'h0;
			bit_reg   <= 4'h0;
			shift_reg <= 8'h00;
			idx_reg   <= 4'h0;
			pins_reg  <= '{scl_low: 1'b0, sda_low: 1'b0};
		end else if (ce) begin
			state_reg <= state_next;
			kind_reg  <= kind_next;
			qtr_reg   <= qtr_next;
			bit_reg   <= bit_next;
			shift_reg <= shift_next;
			idx_reg   <= idx_next;
			pins_reg  <= pins_next;
		end
	end

	// ------------------------------------------------------------
	// open-drain outputs
	// ------------------------------------------------------------
	assign scl_out = 1'b0;
	assign scl_oe  = pins_reg.scl_low;
	assign sda_out = 1'b0;
	assign sda_oe  = pins_reg.sda_low;

endmodule // vpic_host

// File: vpic_host_sva.sv
// concurrent checks on the ports of the serial host controller
`timescale 1ns/10ps
module vpic_host_sva #(
	parameter int QUARTER = vpic_pkg::QUARTER_CYC
) (
	// clock, reset, enable
	input wire logic                clk,
	input wire logic                rst,
	input wire logic                ce,
	// software register port
	input wire vpic_pkg::vpic_bus_s bus,
	input wire logic          [7:0] rdata,
	// serial lines
	input wire logic                scl_in,
	input wire logic                scl_out,
	input wire logic                scl_oe,
	input wire logic                sda_in,
	input wire logic                sda_out,
	input wire logic                sda_oe
);
	// ------------------------------------------------------------
	// helper state: bit and byte tracking on the host's own drives
	// ------------------------------------------------------------
	localparam int GO_LIM   = 2 * QUARTER + 4;   // go to start, slack
	localparam int IDLE_MIN = 2 * QUARTER + 48;  // beyond any gap in frame
	logic        scl_p_reg;                     // last clock enable
	logic        sda_p_reg;                     // last data enable
	logic        first_reg, first_next;         // address byte running
	logic        sel_reg, sel_next;             // register byte running
	logic [3:0]  cnt_reg, cnt_next;             // bit slot in byte
	logic [7:0]  sh_reg, sh_next;               // bits sent so far
	logic [15:0] idle_reg, idle_next;           // cycles both released
	logic [7:0]  rng_reg, rng_next;             // mirror of range
	logic        rise_bit, start_seen, rng_ok, go_ok;
	assign rise_bit   = scl_p_reg && !scl_oe;
	assign start_seen = !sda_p_reg && sda_oe && !scl_oe;
	assign rng_ok = rng_reg[3:0] != 4'h0 && rng_reg[3:0] <= rng_reg[7:4]
		&& rng_reg[7:4] <= 4'hC;
	assign go_ok = ce && bus.wr && bus.addr == vpic_pkg::A_CTRL
		&& bus.wdata[vpic_pkg::CTRL_GO] && idle_reg > IDLE_MIN && rng_ok;
	// next values of the tracking state
	always_comb begin
		cnt_next   = cnt_reg;
		sh_next    = sh_reg;
		first_next = first_reg;
		sel_next   = sel_reg;
		if (start_seen) begin
			cnt_next   = 4'h0;
			first_next = 1'b1;
			sel_next   = 1'b0;
		end else if (rise_bit && cnt_reg == 4'h8) begin
			// ack slot closes the byte
			cnt_next   = 4'h0;
			first_next = 1'b0;
			sel_next   = first_reg ? 1'b1 : !sel_reg;
		end else if (rise_bit) begin
			cnt_next = cnt_reg + 4'h1;
			sh_next  = {sh_reg[6:0], !sda_oe};
		end
		idle_next = (scl_oe || sda_oe) ? 16'h0000 :
			(idle_reg == 16'hFFFF ? idle_reg : idle_reg + 16'h0001);
		rng_next = (bus.wr && bus.addr == vpic_pkg::A_RANGE) ? bus.wdata :
			rng_reg;
	end
	// registers of the tracking state
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			scl_p_reg <= 1'b0;
			sda_p_reg <= 1'b0;
			first_reg <= 1'b0;
			sel_reg   <= 1'b0;
			cnt_reg   <= 4'h0;
			sh_reg    <= 8'h00;
			idle_reg  <= 16'h0000;
			rng_reg   <= vpic_pkg::RST_RANGE;
		end else begin
			scl_p_reg <= scl_oe;
			sda_p_reg <= sda_oe;
			first_reg <= first_next;
			sel_reg   <= sel_next;
			cnt_reg   <= cnt_next;
			sh_reg    <= sh_next;
			idle_reg  <= idle_next;
			rng_reg   <= rng_next;
		end
	end
	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	a_pins_zero: assert property (!scl_out && !sda_out)
		else $error("open drain outputs not held at zero");
	a_reset_release: assert property ($fell(rst) |->
		!scl_oe && !sda_oe && rdata == 8'h00)
		else $error("lines or read data not idle after reset");
	a_rdata_idle: assert property ($past(ce) && !$past(bus.rd) |->
		rdata == 8'h00)
		else $error("read data outside the read answer cycle");
	a_go_start: assert property (go_ok |-> (!scl_oe && !sda_oe) [*8]
		##[1:GO_LIM] (sda_oe && !scl_oe))
		else $error("go did not open with a start");
	a_start_hold: assert property ($rose(sda_oe) && !scl_oe |->
		!scl_oe [*8])
		else $error("clock pulled too soon after start");
	a_sda_stable: assert property ($fell(scl_oe) |-> $stable(sda_oe) [*4])
		else $error("data moved while clock released");
	a_addr_byte: assert property (rise_bit && cnt_reg == 4'h8
		&& first_reg |-> sh_reg == 8'hDC)
		else $error("address byte is not the write address");
	a_ack_release: assert property (rise_bit && cnt_reg == 4'h8
		|-> !sda_oe)
		else $error("host drives data in the ack slot");
	a_reg_select: assert property (rise_bit && cnt_reg == 4'h8 && sel_reg
		|-> sh_reg[7:4] == 4'h0 && sh_reg[3:0] != 4'h0)
		else $error("register select byte out of range");
	a_stop_release: assert property ($fell(sda_oe) && !scl_oe |->
		(!scl_oe && !sda_oe) [*8])
		else $error("lines not left released after stop");
endmodule // vpic_host_sva

bind vpic_host vpic_host_sva #(.QUARTER(QUARTER)) sva_u (
	.clk(clk), .rst(rst), .ce(ce), .bus(bus), .rdata(rdata),
	.scl_in(scl_in), .scl_out(scl_out), .scl_oe(scl_oe),
	.sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe)
);

// File: vpic_dev_model.sv
// behavioural model of the preamp's write-only serial slave
`timescale 1ns/10ps
module vpic_dev_model (
	// clock, reset
	input  wire logic clk,
	input  wire logic rst,
	// resolved serial lines
	input  wire logic scl,
	input  wire logic sda,
	// scenario controls: slow answer, absent device
	input  wire logic stretch,
	input  wire logic refuse,
	// pulls on the lines
	output logic      scl_pull,
	output logic      sda_pull
);
	logic [7:0] regs [1:12];  // control registers
	logic       scl_q, sda_q, on;
	logic [1:0] phase;        // 0 address, 1 select, 2 data
	logic [3:0] cnt, ptr;
	logic [7:0] sh;
	int         hold;         // clock stretch cycles left
	assign scl_pull = (hold != 0);
	// line watcher, shifter and register file
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			for (int i = 1; i <= 12; i++)
				regs[i] <= (i == 1 || (i >= 3 && i <= 5)) ? 8'hB4 : 8'h00;
			on       <= 1'b0;
			sda_pull <= 1'b0;
			hold     <= 0;
			cnt      <= 4'h0;
			scl_q    <= 1'b1;
			sda_q    <= 1'b1;
		end else begin
			scl_q <= scl;
			sda_q <= sda;
			if (hold != 0)
				hold <= hold - 1;
			if (scl && scl_q && sda_q && !sda) begin
				// start: expect the address byte
				on    <= 1'b1;
				phase <= 2'h0;
				cnt   <= 4'h0;
			end else if (scl && scl_q && !sda_q && sda) begin
				on       <= 1'b0;
				sda_pull <= 1'b0;
			end else if (on && scl && !scl_q) begin
				if (cnt < 4'h8)
					sh <= {sh[6:0], sda};
				cnt <= cnt + 4'h1;
			end else if (on && !scl && scl_q && cnt == 4'h8) begin
				// byte complete: acknowledge and store
				sda_pull <= !refuse && (phase != 2'h0 || sh == 8'hDC);
				if (phase == 2'h0 && sh != 8'hDC)
					on <= 1'b0;
				if (phase == 2'h1)
					ptr <= sh[3:0];
				if (phase == 2'h2 && ptr >= 4'h1 && ptr <= 4'hC)
					regs[ptr] <= sh;
				phase <= (phase == 2'h1) ? 2'h2 : 2'h1;
			end else if (on && !scl && scl_q && cnt == 4'h9) begin
				sda_pull <= 1'b0;
				cnt      <= 4'h0;
				if (stretch)
					hold <= 40;
			end
		end
	end
endmodule // vpic_dev_model

// File: vpic_host_bench.sv
// self-checking bench for the serial host controller
`timescale 1ns/10ps
module vpic_host_bench;
	localparam int Q = 8;         // short quarter bit for simulation
	logic                clk, rst, ce, stretch, refuse;
	vpic_pkg::vpic_bus_s bus;
	logic [7:0]          rdata, v;
	logic                scl_oe, sda_oe, scl_out, sda_out;
	logic                d_scl, d_sda, scl_w, sda_w;
	int                  num_errors, checked;
	logic [7:0]          bad [3] = '{8'h35, 8'h50, 8'hD1};
	// pull-up wires: low when any party pulls
	assign scl_w = !(scl_oe || d_scl);
	assign sda_w = !(sda_oe || d_sda);
	vpic_host #(.QUARTER(Q)) dut_u (.clk(clk), .rst(rst), .ce(ce),
		.bus(bus), .rdata(rdata), .scl_in(scl_w), .scl_out(scl_out),
		.scl_oe(scl_oe), .sda_in(sda_w), .sda_out(sda_out), .sda_oe(sda_oe));
	vpic_dev_model dev_u (.clk(clk), .rst(rst), .scl(scl_w), .sda(sda_w),
		.stretch(stretch), .refuse(refuse), .scl_pull(d_scl), .sda_pull(d_sda));
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	// ------------------------------------------------------------
	// shared tasks
	// ------------------------------------------------------------
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		checked++;
		if (seen !== exp) begin
			num_errors++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic results;
		$display("errors %0d, comparisons %0d", num_errors, checked);
		if (num_errors == 0 && checked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	// one-cycle write strobe
	task automatic wr(input logic [4:0] a, input logic [7:0] d);
		@(posedge clk);
		bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge clk);
		bus <= '0;
	endtask
	// read strobe; data stands in the following cycle
	task automatic rd(input logic [4:0] a, output logic [7:0] d);
		@(posedge clk);
		bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
		@(posedge clk);
		bus <= '0;
		#1 d = rdata;
	endtask
	task automatic wait_idle;
		logic [7:0] s;
		for (int n = 0; n < 20000; n++) begin
			rd(vpic_pkg::A_STATUS, s);
			if (s[vpic_pkg::STAT_BUSY] === 1'b0)
				return;
		end
		num_errors++;
		results();
	endtask
	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	task automatic t_reset;
		for (int a = 1; a <= 12; a++) begin
			rd(a[4:0], v);
			check(v, (a == 1 || (a >= 3 && a <= 5)) ? 8'hB4 : 8'h00);
		end
		rd(vpic_pkg::A_CTRL, v);
		check(v, vpic_pkg::RST_CTRL);
		rd(vpic_pkg::A_RANGE, v);
		check(v, vpic_pkg::RST_RANGE);
		rd(5'h1F, v);
		check(v, 8'h00);
	endtask
	// all twelve registers in one frame, device stretching the clock
	task automatic t_full;
		stretch <= 1'b1;
		for (int a = 1; a <= 12; a++)
			wr(a[4:0], 8'h30 + a[7:0]);
		repeat (4 * Q) @(posedge clk);
		wr(vpic_pkg::A_CTRL, 8'h01);
		wr(5'h01, 8'hEE);
		rd(vpic_pkg::A_STATUS, v);
		check(v, 8'h01);
		wait_idle();
		for (int a = 1; a <= 12; a++)
			check(dev_u.regs[a], 8'h30 + a[7:0]);
		rd(vpic_pkg::A_STATUS, v);
		check(v, 8'h00);
		stretch <= 1'b0;
	endtask
	// coupling selections forced on register 9
	task automatic t_modes;
		logic [7:0] e [1:3] = '{8'h54, 8'h5C, 8'h48};
		wr(5'h09, 8'h5C);
		wr(vpic_pkg::A_RANGE, 8'h99);
		for (int m = 1; m <= 3; m++) begin
			wr(vpic_pkg::A_CTRL, {5'h00, m[1:0], 1'b1});
			wait_idle();
			check(dev_u.regs[9], e[m]);
		end
		rd(5'h09, v);
		check(v, 8'h5C);
	endtask
	// running without blanking: brightness zero, clamp route set
	task automatic t_noblank;
		wr(5'h02, 8'h77);
		wr(5'h08, 8'h05);
		wr(vpic_pkg::A_RANGE, 8'h82);
		wr(vpic_pkg::A_CTRL, 8'h09);
		wait_idle();
		check(dev_u.regs[2], 8'h00);
		check(dev_u.regs[8], 8'h85);
		rd(5'h02, v);
		check(v, 8'h77);
	endtask
	// absent device: no acknowledge, sticky flag, clear by write
	task automatic t_nack;
		refuse <= 1'b1;
		wr(5'h01, 8'hA5);
		wr(vpic_pkg::A_RANGE, 8'h11);
		wr(vpic_pkg::A_CTRL, 8'h01);
		wait_idle();
		rd(vpic_pkg::A_STATUS, v);
		check(v, 8'h02);
		check(dev_u.regs[1], 8'h31);
		wr(vpic_pkg::A_STATUS, 8'h02);
		rd(vpic_pkg::A_STATUS, v);
		check(v, 8'h00);
		refuse <= 1'b0;
	endtask
	// invalid ranges refuse go and leave the lines released
	task automatic t_range;
		for (int k = 0; k < 3; k++) begin
			wr(vpic_pkg::A_RANGE, bad[k]);
			wr(vpic_pkg::A_CTRL, 8'h01);
			rd(vpic_pkg::A_STATUS, v);
			check(v, 8'h00);
			repeat (4 * Q) @(posedge clk);
			check({6'h00, scl_oe, sda_oe}, 8'h00);
		end
	endtask
	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial begin
		rst        = 1'b1;
		ce         = 1'b1;
		bus        = '0;
		stretch    = 1'b0;
		refuse     = 1'b0;
		num_errors = 0;
		checked    = 0;
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		t_reset();
		t_full();
		t_modes();
		t_noblank();
		t_nack();
		t_range();
		results();
	end
endmodule // vpic_host_bench
